// *** inc/rss_pkg.sv ***
// constants, types and lookups shared by the reset source sequencer
package rss_pkg;

  // clock and time figures
  localparam int RSS_CLK_NS = 50;
  localparam int RSS_GLITCH_NS = 50;
  // least time rounds up, never below one cycle
  localparam int RSS_GLITCH_CYCLES = (RSS_GLITCH_NS + RSS_CLK_NS - 1) / RSS_CLK_NS < 1 ? 1 :
                                     (RSS_GLITCH_NS + RSS_CLK_NS - 1) / RSS_CLK_NS;
  localparam int RSS_COMPAT_SAMPLE_CYCLES = 6;
  localparam int RSS_COMPAT_HIGH_CYCLES = 12;
  localparam int RSS_COMPAT_SAMPLES = RSS_COMPAT_HIGH_CYCLES / RSS_COMPAT_SAMPLE_CYCLES;
  localparam int RSS_WDOG_PULSE_CYCLES = 16;

  // start-up time-out counts in slow oscillator ticks
  localparam logic [11:0] RSS_TOUT_00 = 12'd2176;
  localparam logic [11:0] RSS_TOUT_01 = 12'd640;
  localparam logic [11:0] RSS_TOUT_10 = 12'd384;
  localparam logic [11:0] RSS_TOUT_11 = 12'd132;

  // warm-up counts in oscillator clocks
  localparam logic [11:0] RSS_WARM_2048 = 12'd2048;
  localparam logic [11:0] RSS_WARM_1024 = 12'd1024;
  localparam logic [11:0] RSS_WARM_256 = 12'd256;
  localparam logic [11:0] RSS_WARM_64 = 12'd64;
  localparam logic [11:0] RSS_WARM_8 = 12'd8;

  // register map, byte addresses on the bus
  localparam logic [7:0] RSS_CAUSE_FLAGS_ADDR = 8'hf8;
  localparam logic [7:0] RSS_CAUSE_FLAGS_RST = 8'h28;
  localparam int RSS_BIT_LPD = 4;
  localparam int RSS_BIT_POR = 3;
  localparam int RSS_BIT_LVR = 2;
  localparam int RSS_BIT_EXR = 1;
  localparam int RSS_BIT_WDR = 0;
  localparam logic [15:0] RSS_RESET_VECTOR = 16'h0000;

  // asynchronous input positions in the synchroniser bank
  localparam int RSS_NUM_ASYNC = 5;
  localparam int RSS_IN_POR = 0;
  localparam int RSS_IN_LVR = 1;
  localparam int RSS_IN_LPD = 2;
  localparam int RSS_IN_PIN = 3;
  localparam int RSS_IN_32K = 4;
  localparam logic [4:0] RSS_ASYNC_RST = 5'h08;

  typedef enum logic [1:0] {RSS_SRC_XTAL, RSS_SRC_CERAMIC, RSS_SRC_IRC, RSS_SRC_EXT} rss_clk_src_t;

  typedef struct packed {
    logic wdtEnable;
    logic fastMode;
    rss_clk_src_t clkSrc;
    logic [1:0] startupTimeoutSelect;
    logic [1:0] warmupCountSelect;
  } rss_fuse_t;

  function automatic logic [11:0] rss_timeout_count(input logic [1:0] sel);
    unique case (sel)
      2'b00: rss_timeout_count = RSS_TOUT_00;
      2'b01: rss_timeout_count = RSS_TOUT_01;
      2'b10: rss_timeout_count = RSS_TOUT_10;
      2'b11: rss_timeout_count = RSS_TOUT_11;
    endcase
  endfunction

  function automatic logic [11:0] rss_warmup_count(input rss_clk_src_t src, input logic [1:0] sel);
    logic [11:0] r;
    r = RSS_WARM_8;
    if (src == RSS_SRC_XTAL || src == RSS_SRC_CERAMIC)
    begin
      unique case (sel)
        2'b00: r = RSS_WARM_2048;
        2'b01: r = RSS_WARM_1024;
        2'b10: r = RSS_WARM_256;
        2'b11: r = RSS_WARM_8;
      endcase
    end
    else if (src == RSS_SRC_IRC)
    begin
      unique case (sel)
        2'b00: r = RSS_WARM_1024;
        2'b01: r = RSS_WARM_256;
        2'b10: r = RSS_WARM_64;
        2'b11: r = RSS_WARM_8;
      endcase
    end
    rss_warmup_count = r;
  endfunction

endpackage

// *** src/rss_reset_sequencer.sv ***
// reset source combiner, start-up sequencer and cause flag register
// Contract
// - during reset all registers reinitialise and fetch starts at address zero.
// - reset comes from power-on, low voltage, reset pin or watchdog.
// - power-on detector activity reasserts reset at once, no delay.
// - power-on reset sets the power-on cause flag.
// - holding the pin low extends reset until the pin releases.
// - time-out select 00..11 gives 2176, 640, 384, 132 slow clocks.
// - time-out is counted on the 32 kHz oscillator.
// - crystal or ceramic warm-up codes give 2048, 1024, 256, 8 clocks.
// - RC warm-up gives 1024, 256, 64, 8; external clock always 8.
// - reset start-up waits time-out then warm-up; stop wake waits warm-up only.
// - low-voltage detection asserts reset immediately.
// - after low-voltage recovery, reset holds until the time-out expires.
// - low-voltage reset sets the low-voltage cause flag.
// - low-power detection only sets its flag, never resets.
// - the reset pin is active low and asserts reset without waiting; the pin's entry here lags the synchroniser and glitch filter.
// - pin pulses shorter than 50 ns are filtered out.
// - compatibility mode samples pin every six clocks, needs twelve clocks high.
// - fast mode samples the pin every clock for release.
// - external pin reset sets the external cause flag.
// - watchdog time-out gives a 16-cycle reset pulse, if fuse-enabled.
// - watchdog reset sets the watchdog cause flag.
// - hardware sets flags, software clears; power-on clears all but its own.
// - any access to the watchdog flag restarts the watchdog when enabled.
// - flags reset to bits 7..6 zero, bit 5 one, power-on one, others zero.
`timescale 1ns/100ps
module rss_reset_sequencer
  import rss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic porActive,
  input wire logic lvrActive,
  input wire logic lpdActive,
  input wire logic reset_pin_n,
  input wire logic clk32k,
  input wire logic wdtTimeout,
  input wire logic stopWake,
  input wire rss_fuse_t fuses,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic sysResetN,
  output logic cpuRun,
  output logic [15:0] fetchAddr,
  output logic wdtRestart
);

  typedef enum logic [2:0] {ST_HOLD, ST_TIMEOUT, ST_WARMUP, ST_RUN, ST_WDOG} rss_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for analog detectors, the pin and the slow oscillator

  logic [RSS_NUM_ASYNC-1:0] asyncIn;
  logic [2:0] syncStage_ff [RSS_NUM_ASYNC];
  logic [RSS_NUM_ASYNC-1:0] stable_ff;

  assign asyncIn = {clk32k, reset_pin_n, lpdActive, lvrActive, porActive};

  // a change counts only once the second and third stages agree; one process keeps one driver per bank
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < RSS_NUM_ASYNC; i++)
        syncStage_ff[i] <= {3{RSS_ASYNC_RST[i]}};
      stable_ff <= RSS_ASYNC_RST;
    end
    else
    begin
      for (int i = 0; i < RSS_NUM_ASYNC; i++)
      begin
        syncStage_ff[i] <= {syncStage_ff[i][1:0], asyncIn[i]};
        if (syncStage_ff[i][1] == syncStage_ff[i][2])
          stable_ff[i] <= syncStage_ff[i][2];
      end
    end
  end

  wire porSync = stable_ff[RSS_IN_POR];
  wire lvrSync = stable_ff[RSS_IN_LVR];
  wire lpdSync = stable_ff[RSS_IN_LPD];
  wire pinHigh = stable_ff[RSS_IN_PIN];

  ////////////////////////////////////////////////////////////////////////////
  // slow oscillator tick and pin glitch filter

  logic slowPrev_ff;
  logic [3:0] pinLowCnt_ff;
  logic [3:0] nxt_pinLowCnt;
  wire slowTick = stable_ff[RSS_IN_32K] & ~slowPrev_ff;

  // glitch filter
  // the low level must survive the agreement stage and the filter count
  assign nxt_pinLowCnt = pinHigh ? 4'h0 :
                         (pinLowCnt_ff == 4'(RSS_GLITCH_CYCLES)) ? pinLowCnt_ff : pinLowCnt_ff + 4'h1;
  wire pinLow = (pinLowCnt_ff == 4'(RSS_GLITCH_CYCLES));

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slowPrev_ff <= 1'b0;
      pinLowCnt_ff <= 4'h0;
    end
    else
    begin
      slowPrev_ff <= stable_ff[RSS_IN_32K];
      pinLowCnt_ff <= nxt_pinLowCnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin release qualification

  logic [2:0] sampleDiv_ff;
  logic [1:0] highSamples_ff;
  logic [2:0] nxt_sampleDiv;
  logic [1:0] nxt_highSamples;

  // compatibility sampling
  // one look every six clocks; the first high sample plus two more span twelve clocks
  wire sampleNow = (sampleDiv_ff == 3'(RSS_COMPAT_SAMPLE_CYCLES - 1));
  assign nxt_sampleDiv = sampleNow ? 3'h0 : sampleDiv_ff + 3'h1;
  assign nxt_highSamples = !pinHigh ? 2'h0 :
                           (sampleNow && highSamples_ff != 2'(RSS_COMPAT_SAMPLES + 1)) ?
                           highSamples_ff + 2'h1 : highSamples_ff;
  // fast mode release
  // fast mode trusts every clock's sample, trading noise margin for speed
  wire pinReleased = fuses.fastMode ? pinHigh :
                     (pinHigh && highSamples_ff == 2'(RSS_COMPAT_SAMPLES + 1));

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sampleDiv_ff <= 3'h0;
      highSamples_ff <= 2'h0;
    end
    else
    begin
      sampleDiv_ff <= nxt_sampleDiv;
      highSamples_ff <= nxt_highSamples;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start-up sequencer

  rss_state_t state_ff;
  rss_state_t nxt_state;
  logic [11:0] cnt_ff;
  logic [11:0] nxt_cnt;
  logic fromStop_ff;
  logic nxt_fromStop;
  logic rstN_ff;

  // reset sources
  // any level source holds the sequencer; the pin also holds until qualified
  wire srcHold = porSync | lvrSync | pinLow | !pinReleased;
  wire wdogFire = wdtTimeout & fuses.wdtEnable;
  wire [11:0] toutCount = rss_timeout_count(fuses.startupTimeoutSelect);
  wire [11:0] warmCount = rss_warmup_count(fuses.clkSrc, fuses.warmupCountSelect);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_fromStop = fromStop_ff;
    unique case (state_ff)
      ST_HOLD:
      begin
        nxt_cnt = 12'h0;
        nxt_fromStop = 1'b0;
        if (!srcHold)
          nxt_state = ST_TIMEOUT;
      end
      ST_TIMEOUT:
      begin
        if (slowTick)
        begin
          nxt_cnt = cnt_ff + 12'h1;
          if (cnt_ff == toutCount - 12'h1)
          begin
            nxt_cnt = 12'h0;
            nxt_state = ST_WARMUP;
          end
        end
      end
      ST_WARMUP:
      begin
        nxt_cnt = cnt_ff + 12'h1;
        if (cnt_ff == warmCount - 12'h1)
        begin
          nxt_cnt = 12'h0;
          nxt_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        nxt_cnt = 12'h0;
        nxt_fromStop = 1'b0;
        if (stopWake)
        begin
          nxt_fromStop = 1'b1;
          nxt_state = ST_WARMUP;
        end
      end
      ST_WDOG:
      begin
        nxt_cnt = cnt_ff + 12'h1;
        if (cnt_ff == 12'(RSS_WDOG_PULSE_CYCLES - 1))
        begin
          nxt_cnt = 12'h0;
          nxt_state = ST_RUN;
        end
      end
    endcase
    if (wdogFire && state_ff != ST_WDOG)
    begin
      nxt_cnt = 12'h0;
      nxt_fromStop = 1'b0;
      nxt_state = ST_WDOG;
    end
    if (srcHold)
    begin
      nxt_cnt = 12'h0;
      nxt_fromStop = 1'b0;
      nxt_state = ST_HOLD;
    end
  end

  // synchronous release
  // release follows the registered state so every register leaves reset together
  wire nxt_rstN = (nxt_state == ST_RUN) || (nxt_state == ST_WARMUP && nxt_fromStop);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= ST_HOLD;
      cnt_ff <= 12'h0;
      fromStop_ff <= 1'b0;
      rstN_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      fromStop_ff <= nxt_fromStop;
      rstN_ff <= nxt_rstN;
    end
  end

  // asynchronous entry
  // raw detector levels bypass the synchronisers so entry needs no clock edge;
  // the pin goes through the glitch filter, so its entry lags a few cycles
  assign sysResetN = rst_b & ~porActive & ~lvrActive & rstN_ff;
  assign cpuRun = sysResetN & (state_ff == ST_RUN);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      fetchAddr <= RSS_RESET_VECTOR;
    else if (!rstN_ff)
      fetchAddr <= RSS_RESET_VECTOR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave and cause flag register

  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic [7:0] setBits;
  logic [7:0] keepBits;
  logic ack_ff;

  wire busReq = wb_cyc_i & wb_stb_i;
  wire busDone = busReq & ack_ff;
  wire hitFlags = (wb_adr_i[7:2] == RSS_CAUSE_FLAGS_ADDR[7:2]);
  wire wrFlags = busDone & wb_we_i & hitFlags & wb_sel_i[0];

  assign setBits = {3'h0, lpdSync, porSync, lvrSync, pinLow, wdogFire};

  // software clear, power-on clear
  // writing zero clears, writing one keeps; a set in the same cycle wins
  assign keepBits = wrFlags ? (flags_ff & {3'h7, wb_dat_i[4:0]}) : flags_ff;
  assign nxt_flags = (porSync ? (keepBits & 8'he8) : keepBits) | setBits;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      flags_ff <= RSS_CAUSE_FLAGS_RST;
    else
      flags_ff <= nxt_flags;
  end

  // registered ack, one wait state; unmapped addresses ack with zero data
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_ff <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      ack_ff <= busReq & ~ack_ff;
      wb_dat_o <= (busReq && hitFlags) ? {24'h0, flags_ff} : 32'h0;
    end
  end
  assign wb_ack_o = ack_ff;

  // access restarts watchdog
  // any access to the flag byte counts, read or write, on its completing edge
  assign wdtRestart = busDone & hitFlags & fuses.wdtEnable;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // pulse-length helper: cycles in the watchdog state with reset low, saturating
  logic [4:0] wdogLen_ff;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      wdogLen_ff <= 5'h0;
    else if (state_ff == ST_WDOG && !rstN_ff)
      wdogLen_ff <= (wdogLen_ff == 5'h1f) ? wdogLen_ff : wdogLen_ff + 5'h1;
    else
      wdogLen_ff <= 5'h0;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_por_reset_now: assert property (porActive |-> !sysResetN)
    else $error("power-on activity did not hold reset");
  a_lvr_reset_now: assert property (lvrActive |-> !sysResetN)
    else $error("low voltage did not hold reset");
  a_por_flag_set: assert property (porSync |=> flags_ff[RSS_BIT_POR] && !flags_ff[RSS_BIT_WDR])
    else $error("power-on flag not set or watchdog flag not cleared");
  a_lvr_flag_set: assert property (lvrSync |=> flags_ff[RSS_BIT_LVR])
    else $error("low-voltage flag not set");
  a_lpd_no_reset: assert property (lpdSync && !srcHold && !wdogFire && state_ff == ST_RUN && !stopWake
                                   |=> flags_ff[RSS_BIT_LPD] && state_ff == ST_RUN)
    else $error("low-power detect disturbed the run state");
  // the pulse length is counted in helper logic rather than unrolled as a long repetition
  a_wdog_pulse_len: assert property ($fell(state_ff == ST_WDOG) && state_ff == ST_RUN
                                     |-> rstN_ff && wdogLen_ff == 5'(RSS_WDOG_PULSE_CYCLES))
    else $error("watchdog reset pulse length wrong");
  a_timeout_end: assert property (state_ff == ST_TIMEOUT && slowTick && cnt_ff == toutCount - 12'h1
                                  && !srcHold && !wdogFire |=> state_ff == ST_WARMUP && !rstN_ff)
    else $error("time-out did not hand over to warm-up");
  a_stop_warmup: assert property (state_ff == ST_RUN && stopWake && !srcHold && !wdogFire
                                  |=> state_ff == ST_WARMUP && rstN_ff && !cpuRun)
    else $error("stop wake did not go straight to warm-up");
  a_wdr_restart: assert property (busDone && hitFlags |-> wdtRestart == fuses.wdtEnable)
    else $error("flag access did not restart the watchdog");
  a_pin_holds: assert property (pinLow |=> state_ff == ST_HOLD && !sysResetN)
    else $error("low reset pin did not hold reset");
  a_compat_release: assert property (!fuses.fastMode && state_ff == ST_HOLD && !srcHold
                                     |-> $past(pinHigh, RSS_COMPAT_HIGH_CYCLES))
    else $error("compatibility release came before twelve high clocks");

endmodule

// *** sim/rss_supply_model.sv ***
// far-side model: supply detectors, reset pin driver and slow oscillator
`timescale 1ns/100ps
module rss_supply_model
(
  input wire logic ref_clk,
  input wire logic porReq,
  input wire logic lvrReq,
  input wire logic lpdReq,
  input wire logic pinLowReq,
  input wire logic glitchReq,
  output logic porActive,
  output logic lvrActive,
  output logic lpdActive,
  output logic reset_pin_n,
  output logic clk32k
);
  logic glitchLow;
  logic [1:0] divCnt;
  ////////////////////////////////////////////////////////////
  // detector levels follow the requested supply state
  assign porActive = porReq;
  assign lvrActive = lvrReq;
  assign lpdActive = lpdReq;
  // pin active low
  // pulled up, so a released pin reads high, never a stale level
  assign reset_pin_n = ~(pinLowReq | glitchLow);
  ////////////////////////////////////////////////////////////
  // short pin spike
  // 20 ns spike straddling a clock edge, so one sample does see it
  initial glitchLow = 1'b0;
  always @(posedge glitchReq)
  begin
    #40 glitchLow = 1'b1;
    #20 glitchLow = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // free running slow oscillator
  // sped up to a 4-clock half period so the time-out fits the run
  initial
  begin
    divCnt = 2'h0;
    clk32k = 1'b0;
  end
  always @(posedge ref_clk)
  begin
    divCnt <= divCnt + 2'h1;
    if (divCnt == 2'h3)
      clk32k <= ~clk32k;
  end
endmodule

// *** sim/rss_reset_sequencer_tb.sv ***
// self-checking testbench for the reset source sequencer
`timescale 1ns/100ps
module rss_reset_sequencer_tb
  import rss_pkg::*;
;
  // 132 ticks of 8 clocks, plus warm-up and synchroniser slack
  localparam int STARTUP_LO = 1040;
  localparam int STARTUP_HI = 1110;
  logic ref_clk, rst_b, porReq, lvrReq, lpdReq, pinLowReq, glitchReq;
  logic porActive, lvrActive, lpdActive, reset_pin_n, clk32k;
  logic wdtTimeout, stopWake, cyc, stb, wbWe, wbAck, sysResetN, cpuRun, wdtRestart;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, rdData;
  logic [15:0] fetchAddr;
  logic rdRestart;
  rss_fuse_t fuses;
  int numErrors;
  int cmpCount;
  ////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  rss_reset_sequencer dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .porActive(porActive), .lvrActive(lvrActive),
    .lpdActive(lpdActive), .reset_pin_n(reset_pin_n), .clk32k(clk32k), .wdtTimeout(wdtTimeout),
    .stopWake(stopWake), .fuses(fuses), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .sysResetN(sysResetN),
    .cpuRun(cpuRun), .fetchAddr(fetchAddr), .wdtRestart(wdtRestart));
  rss_supply_model model_u (.ref_clk(ref_clk), .porReq(porReq), .lvrReq(lvrReq), .lpdReq(lpdReq),
    .pinLowReq(pinLowReq), .glitchReq(glitchReq), .porActive(porActive), .lvrActive(lvrActive),
    .lpdActive(lpdActive), .reset_pin_n(reset_pin_n), .clk32k(clk32k));
  ////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic closeOut;
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one classic bus cycle, held until ack, released at that edge
  task automatic wbXfer(input logic write, input logic [7:0] addr, input logic [7:0] wdat);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbWe <= write;
    wbAdr <= addr;
    wbSel <= 4'h1;
    wbDatI <= {24'h000000, wdat};
    // no cycle limit here; only the bench watchdog ends a hung wait
    do
    begin
      @(posedge ref_clk);
    end
    while (wbAck !== 1'b1);
    rdData = wbDatO;
    rdRestart = wdtRestart;
    cyc <= 1'b0;
    stb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic readFlags(input logic [7:0] exp);
    wbXfer(1'b0, RSS_CAUSE_FLAGS_ADDR, 8'h00);
    check(rdData, {24'h000000, exp});
  endtask
  // bounded wait for release, judged against the start-up window
  task automatic waitRelease;
    int n;
    n = 0;
    while (sysResetN !== 1'b1 && n < 3000)
    begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, (n >= STARTUP_LO && n <= STARTUP_HI)}, 32'h1);
  endtask
  // counts clocks with reset low over a span, and clocks with cpuRun low too
  task automatic countLow(input int span, output int nRst, output int nRun);
    nRst = 0;
    nRun = 0;
    repeat (span)
    begin
      @(posedge ref_clk);
      wdtTimeout <= 1'b0;
      stopWake <= 1'b0;
      glitchReq <= 1'b0;
      if (sysResetN !== 1'b1)
        nRst++;
      if (cpuRun !== 1'b1)
        nRun++;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic tPowerUp;
    readFlags(8'h28);
    check({16'h0, fetchAddr}, 32'h0);
    check({31'h0, sysResetN}, 32'h0);
    waitRelease();
    @(posedge ref_clk);
    check({31'h0, cpuRun}, 32'h1);
    $display("power-up test done");
  endtask
  task automatic tSoftware;
    wbXfer(1'b1, RSS_CAUSE_FLAGS_ADDR, 8'h00);
    check({31'h0, rdRestart}, 32'h1);
    readFlags(8'h20);
    check({31'h0, rdRestart}, 32'h1);
    wbXfer(1'b0, 8'h10, 8'h00);
    check(rdData, 32'h0);
    $display("software access test done");
  endtask
  task automatic tEvents;
    int nRst;
    int nRun;
    @(posedge ref_clk);
    lpdReq <= 1'b1;
    countLow(20, nRst, nRun);
    lpdReq <= 1'b0;
    check(nRst, 32'h0);
    readFlags(8'h30);
    @(posedge ref_clk);
    wdtTimeout <= 1'b1;
    countLow(40, nRst, nRun);
    check(nRst, 32'h10);
    readFlags(8'h31);
    @(posedge ref_clk);
    stopWake <= 1'b1;
    countLow(30, nRst, nRun);
    check(nRst, 32'h0);
    check({31'h0, (nRun >= 8 && nRun <= 9)}, 32'h1);
    wbXfer(1'b1, RSS_CAUSE_FLAGS_ADDR, 8'h00);
    @(posedge ref_clk);
    glitchReq <= 1'b1;
    countLow(20, nRst, nRun);
    check(nRst, 32'h0);
    readFlags(8'h20);
    $display("event test done");
  endtask
  task automatic tPinHold;
    int nHigh;
    nHigh = 0;
    @(posedge ref_clk);
    pinLowReq <= 1'b1;
    repeat (10) @(posedge ref_clk);
    repeat (1500)
    begin
      @(posedge ref_clk);
      if (sysResetN !== 1'b0)
        nHigh++;
    end
    check(nHigh, 32'h0);
    pinLowReq <= 1'b0;
    waitRelease();
    readFlags(8'h22);
    $display("pin hold test done");
  endtask
  // compatibility mode: release needs the pin high across three samples
  task automatic tCompat;
    @(posedge ref_clk);
    fuses.fastMode <= 1'b0;
    pinLowReq <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check({31'h0, sysResetN}, 32'h0);
    pinLowReq <= 1'b0;
    waitRelease();
    readFlags(8'h22);
    fuses.fastMode <= 1'b1;
    $display("compatibility pin test done");
  endtask
  task automatic tSupply;
    @(posedge ref_clk);
    lvrReq <= 1'b1;
    #1;
    check({31'h0, sysResetN}, 32'h0);
    repeat (20) @(posedge ref_clk);
    lvrReq <= 1'b0;
    waitRelease();
    readFlags(8'h26);
    @(posedge ref_clk);
    porReq <= 1'b1;
    #1;
    check({31'h0, sysResetN}, 32'h0);
    repeat (20) @(posedge ref_clk);
    porReq <= 1'b0;
    waitRelease();
    readFlags(8'h28);
    $display("supply test done");
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence; all inputs defined at time zero
  initial
  begin
    numErrors = 0;
    cmpCount = 0;
    {rst_b, porReq, lvrReq, lpdReq, pinLowReq, glitchReq, wdtTimeout, stopWake} = 8'h00;
    {cyc, stb, wbWe, wbAdr, wbSel, wbDatI} = '0;
    fuses = '{wdtEnable: 1'b1, fastMode: 1'b1, clkSrc: RSS_SRC_EXT, startupTimeoutSelect: 2'b11,
              warmupCountSelect: 2'b00};
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    tPowerUp();
    tSoftware();
    tEvents();
    tPinHold();
    tCompat();
    tSupply();
    closeOut();
  end
  // watchdog: the run needs about 7100 clocks
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    numErrors++;
    $display("timeout: run did not finish");
    closeOut();
  end
endmodule
